// >>> rtl/pls_port_led_status_driver.sv
// Function
// (R01) each port has three active-low indicator outputs, low meaning lit.
// (R02) lit periods are stretched unless the bypass configuration bit is set.
// (R03) indicator a shows transmit by default, selectable to receive, link or full duplex.
// (R04) indicator b shows receive by default, selectable to link, full duplex or speed.
// (R05) indicator c shows link by default, selectable to full duplex, speed or collision.
// (R06) the serial frame holds port 0 in bits 23..18 down to port 3 in 5..0, order T R L D S C, MSB first.
// (R07) activity, link and collision bits are 0 when active, duplex 1 when full, speed 1 for 10 Mbps.
// (R08) a full 24-bit burst is sent every 1 ms even without change.
// (R09) any status change triggers an extra burst, respecting a 10 us minimum gap between bursts.
// (R10) the frame strobe is high exactly for the 24 data bits and the receiver samples only then.
// (R11) stretch length, bit rate and change detection derive from the clock; stretch restarts per event.
`timescale 1ns/1ps
module pls_port_led_status_driver #(
  parameter int STRETCH_CYCLES = pls_pkg::STRETCH_CYC,
  parameter int PERIOD_CYCLES = pls_pkg::PERIOD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // per-port status from the phy core
  input wire logic [3:0] tx_active,
  input wire logic [3:0] rx_active,
  input wire logic [3:0] link_up,
  input wire logic [3:0] full_duplex,
  input wire logic [3:0] speed_100,
  input wire logic [3:0] collision,
  // indicator pins, active low
  output logic [3:0] port_indicator_a_n,
  output logic [3:0] port_indicator_b_n,
  output logic [3:0] port_indicator_c_n,
  // serial status link
  output logic serial_status_out,
  output logic serial_status_frame
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic pick4(input logic [1:0] sel, input logic s0, input logic s1,
                                 input logic s2, input logic s3);
    logic r;
    r = s0;
    if (sel == 2'h1) begin
      r = s1;
    end else if (sel == 2'h2) begin
      r = s2;
    end else if (sel == 2'h3) begin
      r = s3;
    end
    return r;
  endfunction : pick4

  // ----------------------------------------------------------------
  // registers and bus slave
  // ----------------------------------------------------------------
  logic cfg_bypass;
  logic [23:0] led_sel;
  logic [23:0] last_sent;
  logic bus_ack;
  logic [11:0] led_on;
  pls_pkg::pls_state_e state;

  wire bus_req = avs_read | avs_write;
  wire hit_cfg = avs_address == pls_pkg::CFG_ADDR;
  wire hit_sel = avs_address == pls_pkg::SEL_ADDR;
  wire hit_frame = avs_address == pls_pkg::FRAME_ADDR;
  wire hit_leds = avs_address == pls_pkg::LEDS_ADDR;
  wire wr_fire = avs_write & bus_ack;
  wire busy = state == pls_pkg::PLS_SHIFT;
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_cfg) begin
      rd_mux[pls_pkg::CFG_BYPASS_BIT] = cfg_bypass;
    end else if (hit_sel) begin
      rd_mux[23:0] = led_sel;
    end else if (hit_frame) begin
      rd_mux[23:0] = last_sent;
      rd_mux[pls_pkg::FRAME_BUSY_BIT] = busy;
    end else if (hit_leds) begin
      rd_mux[11:0] = led_on;
    end
  end

  // one wait state: data is registered in the first cycle, ready in the second
  assign avs_waitrequest = bus_req & ~bus_ack;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (avs_read & ~bus_ack) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_bypass <= pls_pkg::CFG_RESET;
      led_sel <= pls_pkg::SEL_RESET;
    end else begin
      if (wr_fire && hit_cfg && avs_byteenable[0]) begin
        cfg_bypass <= avs_writedata[pls_pkg::CFG_BYPASS_BIT]; // R02
      end
      if (wr_fire && hit_sel) begin
        for (int i = 0; i < 3; i++) begin
          if (avs_byteenable[i]) begin
            led_sel[i*8 +: 8] <= avs_writedata[i*8 +: 8];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // indicator selection and stretching
  // ----------------------------------------------------------------
  logic [11:0] raw_on;

  genvar p;
  generate
    for (p = 0; p < pls_pkg::NUM_PORTS; p++) begin : g_port
      wire [5:0] sel = led_sel[p*6 +: 6];
      assign raw_on[p*3+0] = pick4(sel[1:0], tx_active[p], rx_active[p], link_up[p],
                                   full_duplex[p]); // R03
      assign raw_on[p*3+1] = pick4(sel[3:2], rx_active[p], link_up[p], full_duplex[p],
                                   speed_100[p]); // R04
      assign raw_on[p*3+2] = pick4(sel[5:4], link_up[p], full_duplex[p], speed_100[p],
                                   collision[p]); // R05
      assign port_indicator_a_n[p] = ~led_on[p*3+0]; // R01
      assign port_indicator_b_n[p] = ~led_on[p*3+1]; // R01
      assign port_indicator_c_n[p] = ~led_on[p*3+2]; // R01
    end

    for (p = 0; p < pls_pkg::NUM_LEDS; p++) begin : g_led
      logic [pls_pkg::CNT_W-1:0] hold;
      // counter reloads while the source is active, so each new event restarts it
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          hold <= '0;
        end else if (raw_on[p]) begin
          hold <= pls_pkg::CNT_W'(STRETCH_CYCLES - 1); // R11
        end else if (cfg_bypass) begin
          // a stale count must not light the pin once bypass is cleared
          hold <= '0;
        end else if (hold != '0) begin
          hold <= hold - 1'b1;
        end
      end
      // registered so the pins never glitch on select changes
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          led_on[p] <= 1'b0;
        end else begin
          led_on[p] <= raw_on[p] | (~cfg_bypass & (hold != '0)); // R02
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // serial status frame
  // ----------------------------------------------------------------
  logic [23:0] status_vec;
  logic [23:0] shreg;
  logic [4:0] bit_idx;
  logic [7:0] tick;
  logic [pls_pkg::CNT_W-1:0] period_cnt;
  logic [pls_pkg::CNT_W-1:0] gap_cnt;

  generate
    for (p = 0; p < pls_pkg::NUM_PORTS; p++) begin : g_vec
      assign status_vec[23-p*6 -: 6] = {~tx_active[p], ~rx_active[p], ~link_up[p],
                                        full_duplex[p], ~speed_100[p], ~collision[p]}; // R06 R07
    end
  endgenerate

  wire changed = status_vec != last_sent; // R09
  wire period_due = period_cnt >= pls_pkg::CNT_W'(PERIOD_CYCLES - 1); // R08
  wire gap_ok = gap_cnt >= pls_pkg::CNT_W'(pls_pkg::GAP_CYC); // R09
  wire start = ~busy & gap_ok & (period_due | changed);
  wire bit_end = tick == 8'(pls_pkg::BIT_CYC - 1); // R11
  wire last_bit = bit_idx == 5'(pls_pkg::FRAME_BITS - 1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= '0;
    end else if (start) begin
      period_cnt <= '0; // R08
    end else if (!period_due) begin
      period_cnt <= period_cnt + 1'b1;
    end
  end

  // gap counts from the end of one burst; it starts satisfied after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= pls_pkg::CNT_W'(pls_pkg::GAP_CYC);
    end else if (busy) begin
      gap_cnt <= '0; // R09
    end else if (!gap_ok) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  pls_pkg::pls_state_e next_state;
  wire step = busy & bit_end & ~last_bit;
  wire done = busy & bit_end & last_bit;

  always_comb begin
    next_state = state;
    case (state)
      pls_pkg::PLS_IDLE: begin
        if (start) begin
          next_state = pls_pkg::PLS_SHIFT;
        end
      end
      pls_pkg::PLS_SHIFT: begin
        if (bit_end && last_bit) begin
          next_state = pls_pkg::PLS_IDLE;
        end
      end
      default: begin
        next_state = pls_pkg::PLS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pls_pkg::PLS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= '0;
    end else if (busy && !bit_end) begin
      tick <= tick + 1'b1;
    end else begin
      tick <= '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx <= '0;
    end else if (start) begin
      bit_idx <= '0;
    end else if (step) begin
      bit_idx <= bit_idx + 1'b1;
    end
  end

  // last_sent doubles as the change reference, so it loads with the frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= pls_pkg::FRAME_RESET;
      last_sent <= pls_pkg::FRAME_RESET;
    end else if (start) begin
      shreg <= status_vec;
      last_sent <= status_vec;
    end else if (step) begin
      shreg <= {shreg[22:0], 1'b1};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_status_frame <= 1'b0;
    end else if (start) begin
      serial_status_frame <= 1'b1; // R10
    end else if (done) begin
      serial_status_frame <= 1'b0; // R10
    end
  end

  // line idles high between frames
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_status_out <= 1'b1;
    end else if (start) begin
      serial_status_out <= status_vec[23]; // R06
    end else if (step) begin
      serial_status_out <= shreg[22]; // R06
    end else if (done) begin
      serial_status_out <= 1'b1;
    end
  end

endmodule : pls_port_led_status_driver

// >>> rtl/pls_pkg.sv
package pls_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int STRETCH_US = 100000;
  localparam int STRETCH_CYC = STRETCH_US * CLK_MHZ;
  localparam int PERIOD_US = 1000;
  localparam int PERIOD_CYC = PERIOD_US * CLK_MHZ;
  localparam int GAP_US = 10;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int BIT_NS = 200;
  localparam int BIT_CYC = (BIT_NS * CLK_MHZ) / 1000;
  localparam int FRAME_BITS = 24;
  localparam int PORT_BITS = 6;
  localparam int NUM_PORTS = 4;
  localparam int NUM_LEDS = 12;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] CFG_ADDR = 4'h0;
  localparam logic [3:0] SEL_ADDR = 4'h4;
  localparam logic [3:0] FRAME_ADDR = 4'h8;
  localparam logic [3:0] LEDS_ADDR = 4'hC;
  localparam int CFG_BYPASS_BIT = 0;
  localparam int FRAME_BUSY_BIT = 24;
  localparam logic CFG_RESET = 1'h0;
  localparam logic [23:0] SEL_RESET = 24'h000000;
  localparam logic [23:0] FRAME_RESET = 24'hFFFFFF;

  // ----------------------------------------------------------------
  // indicator source selections
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_A_TX = 2'h0;
  localparam logic [1:0] SRC_A_RX = 2'h1;
  localparam logic [1:0] SRC_A_LINK = 2'h2;
  localparam logic [1:0] SRC_A_DUP = 2'h3;
  localparam logic [1:0] SRC_B_RX = 2'h0;
  localparam logic [1:0] SRC_B_LINK = 2'h1;
  localparam logic [1:0] SRC_B_DUP = 2'h2;
  localparam logic [1:0] SRC_B_SPD = 2'h3;
  localparam logic [1:0] SRC_C_LINK = 2'h0;
  localparam logic [1:0] SRC_C_DUP = 2'h1;
  localparam logic [1:0] SRC_C_SPD = 2'h2;
  localparam logic [1:0] SRC_C_COL = 2'h3;

  typedef enum logic {PLS_IDLE, PLS_SHIFT} pls_state_e;
endpackage : pls_pkg

// >>> verif/pls_led_monitor.sv
`timescale 1ns/1ps
module pls_led_monitor #(
  parameter int PERIOD_CYCLES = 400
) (
  // clock, reset, bus
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // status
  input wire logic [3:0] tx_active,
  input wire logic [3:0] rx_active,
  input wire logic [3:0] link_up,
  input wire logic [3:0] full_duplex,
  input wire logic [3:0] speed_100,
  input wire logic [3:0] collision,
  // pins
  input wire logic [3:0] port_indicator_a_n,
  input wire logic [3:0] port_indicator_b_n,
  input wire logic [3:0] port_indicator_c_n,
  input wire logic serial_status_out,
  input wire logic serial_status_frame
);
  logic [7:0] fcnt;
  logic [15:0] icnt;
  logic seen;
  // seen masks the first burst, which has no gap or period before it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt <= 8'h00;
      icnt <= 16'h0000;
      seen <= 1'b0;
    end else begin
      fcnt <= serial_status_frame ? fcnt + 8'h01 : 8'h00;
      icnt <= serial_status_frame ? 16'h0000 : icnt + 16'h0001;
      seen <= seen | $fell(serial_status_frame);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  sequence s_mid_bit; serial_status_frame && fcnt[1:0] != 2'h0; endsequence
  property p_wait; $rose(avs_read | avs_write) |-> s_one_wait; endproperty
  a_wait: assert property (p_wait) else $error("wait state count");
  property p_bit_hold; s_mid_bit |-> $stable(serial_status_out); endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit not held");
  property p_frame_len; $fell(serial_status_frame) |-> fcnt == 8'h60; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length");
  property p_gap; $rose(serial_status_frame) && seen |-> icnt >= 16'h00C8; endproperty
  a_gap: assert property (p_gap) else $error("burst gap short");
  property p_period; seen && !serial_status_frame |-> icnt < PERIOD_CYCLES - 96; endproperty
  a_period: assert property (p_period) else $error("periodic burst late");
  property p_change;
    seen && !serial_status_frame && icnt > 16'h00C8 && $changed(link_up) |->
      ##[1:2] serial_status_frame;
  endproperty
  a_change: assert property (p_change) else $error("no burst on change");
  property p_ind_a;
    (~port_indicator_a_n & $past(port_indicator_a_n)
      & ~$past(tx_active | rx_active | link_up | full_duplex)) == 4'h0;
  endproperty
  a_ind_a: assert property (p_ind_a) else $error("indicator a lit unsourced");
  property p_ind_b;
    (~port_indicator_b_n & $past(port_indicator_b_n)
      & ~$past(rx_active | link_up | full_duplex | speed_100)) == 4'h0;
  endproperty
  a_ind_b: assert property (p_ind_b) else $error("indicator b lit unsourced");
  property p_ind_c;
    (~port_indicator_c_n & $past(port_indicator_c_n)
      & ~$past(link_up | full_duplex | speed_100 | collision)) == 4'h0;
  endproperty
  a_ind_c: assert property (p_ind_c) else $error("indicator c lit unsourced");
endmodule : pls_led_monitor
bind pls_port_led_status_driver pls_led_monitor #(.PERIOD_CYCLES(PERIOD_CYCLES))
  i_pls_led_monitor (.*);

// >>> verif/pls_shift_model.sv
`timescale 1ns/1ps
module pls_shift_model (
  // link from the device
  input wire logic core_clk,
  input wire logic serial_status_frame,
  input wire logic serial_status_out,
  // last captured frame
  output logic [23:0] word,
  output int frames
);
  logic [1:0] ph;
  logic [23:0] sh;
  logic was;
  initial begin
    frames = 0;
    ph = 2'h0;
    was = 1'b0;
  end
  // sample mid-bit, only while strobed
  always @(posedge core_clk) begin
    was <= serial_status_frame;
    ph <= serial_status_frame ? ph + 2'h1 : 2'h0;
    if (serial_status_frame && ph == 2'h1) begin
      sh <= {sh[22:0], serial_status_out};
    end
    if (was && !serial_status_frame) begin
      word <= sh;
      frames <= frames + 1;
    end
  end
endmodule : pls_shift_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int STRETCH = 20;
  localparam int PERIOD = 400;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, ser_out, ser_frame;
  logic [3:0] avs_address, led_a_n, led_b_n, led_c_n;
  logic [31:0] avs_writedata, avs_readdata, rd, seed;
  logic [23:0] st, word;
  int frames, n_mismatch, comparisons, cycles;

  pls_port_led_status_driver #(.STRETCH_CYCLES(STRETCH), .PERIOD_CYCLES(PERIOD))
    i_pls_port_led_status_driver (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_active(st[3:0]),
    .rx_active(st[7:4]), .link_up(st[11:8]), .full_duplex(st[15:12]), .speed_100(st[19:16]),
    .collision(st[23:20]), .port_indicator_a_n(led_a_n), .port_indicator_b_n(led_b_n),
    .port_indicator_c_n(led_c_n), .serial_status_out(ser_out), .serial_status_frame(ser_frame)
  );
  pls_shift_model i_pls_shift_model (.core_clk(core_clk), .serial_status_frame(ser_frame),
    .serial_status_out(ser_out), .word(word), .frames(frames));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [31:0] frame_exp(input logic [23:0] s);
    logic [31:0] f;
    f = 32'h00000000;
    for (int p = 0; p < 4; p++) begin
      f[23 - 6 * p -: 6] = {~s[p], ~s[4 + p], ~s[8 + p], s[12 + p], ~s[16 + p], ~s[20 + p]};
    end
    return f;
  endfunction : frame_exp
  // source nibble of indicator k under selection m is k + m
  function automatic logic [31:0] led_exp(input logic [23:0] s, input int k, input int m);
    return {28'h0000000, ~s[4 * (k + m) +: 4]};
  endfunction : led_exp
  // lit register bit 3p+k follows the selected source of indicator k on port p
  function automatic logic [31:0] leds_exp(input logic [23:0] s, input int m);
    logic [31:0] f;
    f = 32'h00000000;
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 3; k++) begin
        f[3 * p + k] = s[4 * (k + m) + p];
      end
    end
    return f;
  endfunction : leds_exp
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wait_frame();
    int t0;
    t0 = frames;
    while (frames == t0) @(posedge core_clk);
  endtask : wait_frame
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {n_mismatch, comparisons, cycles} = '0;
    seed = 32'h000172D6;
    st = 24'h000F00;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk("cfg", 32'h0, rd);
    bus(1'b0, 4'h4, 32'h0);
    chk("sel", 32'h0, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    wait_frame();
    // changes land after the gap, so each one sends at once; pass 2 keeps st and waits for the periodic burst
    for (int i = 0; i < 8; i++) begin
      repeat (210) @(posedge core_clk);
      seed = xs(seed);
      st <= (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h000000 : (i == 2) ? st : seed[23:0];
      wait_frame();
      chk("frame", frame_exp(st), {8'h00, word});
      bus(1'b0, 4'h8, 32'h0);
      chk("frame reg", frame_exp(st), {8'h00, rd[23:0]});
    end
    bus(1'b1, 4'h0, 32'h1);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 4'h4, {8'h00, {4{{3{m[1:0]}}}}});
      for (int j = 0; j < 4; j++) begin
        seed = xs(seed);
        st <= seed[23:0];
        repeat (2) @(posedge core_clk);
        chk("ind a", led_exp(st, 0, m), {28'h0, led_a_n});
        chk("ind b", led_exp(st, 1, m), {28'h0, led_b_n});
        chk("ind c", led_exp(st, 2, m), {28'h0, led_c_n});
        bus(1'b0, 4'hC, 32'h0);
        chk("lit reg", leds_exp(st, m), rd);
      end
    end
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h0, 32'h0);
    st <= 24'h000000;
    repeat (STRETCH + 5) @(posedge core_clk);
    chk("off", 32'hF, {28'h0, led_a_n});
    st <= 24'h00000F;
    repeat (2) @(posedge core_clk);
    st <= 24'h000000;
    repeat (5) @(posedge core_clk);
    chk("stretched", 32'h0, {28'h0, led_a_n});
    st <= 24'h00000F;
    @(posedge core_clk);
    st <= 24'h000000;
    repeat (18) @(posedge core_clk);
    chk("restarted", 32'h0, {28'h0, led_a_n});
    repeat (6) @(posedge core_clk);
    chk("expired", 32'hF, {28'h0, led_a_n});
    finish_test();
  end
endmodule : tb_top
